//--- src/xfer_engine_pkg.sv
// Constants, types and field layouts of the data transfer engine
// Functional notes
// - Source address fixed, incremented or decremented
// - Destination address updated independently of source
// - Normal mode moves one unit per activation
// - Repeat mode reloads area address and count, continues
// - Block mode moves one whole block per activation
// - Area bit picks side restored after cycle
// - Unit size is byte or word
// - Block-size counter is eight bits wide
// - Count 16 bits; repeat uses 8-bit count
// - One selected activation source starts each sequence
// - Interrupt at zero count outside repeat mode, or every transfer
// - Chained set follows, always or at zero
package xfer_engine_pkg;
   // Address and data widths of the memory port
   localparam int ADDR_W     = 32;
   localparam int DATA_W     = 32;
   // Parameter set: four words, set size in bytes, word indices
   localparam int SET_WORDS  = 4;
   localparam logic [ADDR_W-1:0] SET_BYTES = 32'h0000_0010;
   localparam logic [ADDR_W-1:0] ALIGN_MASK = 32'hffff_fffc;
   localparam logic [1:0] W_CFG = 2'h0;  // Configuration word
   localparam logic [1:0] W_SRC = 2'h1;  // Source address word
   localparam logic [1:0] W_DST = 2'h2;  // Destination address word
   localparam logic [1:0] W_CNT = 2'h3;  // Counts word
   // Counts word field positions
   localparam int CNT_LSB    = 0;   // Transfer count, 16 bits
   localparam int BLK_LSB    = 16;  // Block counter, 8 bits
   localparam int BLKR_LSB   = 24;  // Block size reload, 8 bits
   // Reset values
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [7:0]  BLK_RST = 8'h00;
   // Address operation codes
   typedef enum logic [1:0]
   {
      OP_FIXED = 2'h0,
      OP_INC   = 2'h1,
      OP_DEC   = 2'h2
   } addr_op_t;
   // Transfer modes
   typedef enum logic [1:0]
   {
      MODE_NORMAL = 2'h0,
      MODE_REPEAT = 2'h1,
      MODE_BLOCK  = 2'h2
   } xfer_mode_t;
   // Configuration word, high bits first
   typedef struct packed
   {
      logic [20:0] spare;        // Reads back unchanged
      logic        irq_each;     // Interrupt after every operation
      logic        chain_zero;   // Chain only when count reaches zero
      logic        chain_en;     // Chain to following set
      logic        word_size;    // 1 word, 0 byte
      logic        area_dst;     // 1 destination is area, 0 source
      xfer_mode_t  mode;         // Transfer mode
      addr_op_t    dst_op;       // Destination update
      addr_op_t    src_op;       // Source update
   } xfer_cfg_t;
   // Memory command carried to the system bus
   typedef struct packed
   {
      logic              req;    // Request, held until acknowledged
      logic              we;     // Write
      logic              word;   // Word access, else byte
      logic [ADDR_W-1:0] addr;   // Byte address
      logic [DATA_W-1:0] wdata;  // Write data
   } mem_cmd_t;
endpackage : xfer_engine_pkg

//--- src/data_transfer_engine.sv
// Data transfer engine: activation, set fetch, moves and write back
`timescale 1ns/10ps
module data_transfer_engine
#(
   parameter int NUM_SRC = 8    // Activation sources, software among them
)
(
   // Clock and reset
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_in,
   // Activation requests and vector table base
   input  wire logic [NUM_SRC-1:0]            act_req_in,
   input  wire logic [xfer_engine_pkg::ADDR_W-1:0] vec_base_in,
   output logic      [NUM_SRC-1:0]            act_ack_out,
   // Memory port
   output xfer_engine_pkg::mem_cmd_t          mem_cmd_out,
   input  wire logic [xfer_engine_pkg::DATA_W-1:0] mem_rdata_in,
   input  wire logic                          mem_ack_in,
   // Status
   output logic                               busy_out,
   output logic                               cpu_irq_out
);
   import xfer_engine_pkg::*;

   // Engine states, Gray along the usual path except ST_DONE to ST_IDLE
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_VEC   = 3'b001,
      ST_FETCH = 3'b011,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b110,
      ST_WBACK = 3'b111,
      ST_DONE  = 3'b101
   } eng_state_t;

   eng_state_t           st_ff,   nxt_st;       // Engine state
   logic [ADDR_W-1:0]    base_ff, nxt_base;     // Current set base
   logic [1:0]           wi_ff,   nxt_wi;       // Set word index
   xfer_cfg_t            cfg_ff,  nxt_cfg;      // Configuration word
   logic [ADDR_W-1:0]    src_ff,  nxt_src;      // Source address
   logic [ADDR_W-1:0]    dst_ff,  nxt_dst;      // Destination address
   logic [15:0]          cnt_ff,  nxt_cnt;      // Transfer count
   logic [7:0]           blk_ff,  nxt_blk;      // Block counter
   logic [7:0]           blkr_ff, nxt_blkr;     // Block size reload
   logic [15:0]          dat_ff,  nxt_dat;      // Unit in flight
   mem_cmd_t             cmd_ff,  nxt_cmd;      // Memory command
   logic [NUM_SRC-1:0]   ack_ff,  nxt_ack;      // Activation accept
   logic                 irq_ff,  nxt_irq;      // CPU interrupt pulse
   logic                 busy_ff, nxt_busy;     // Engine busy
   logic                 acc;                   // Memory access done

   // Lowest pending activation source
   function automatic logic [NUM_SRC-1:0] pick(input logic [NUM_SRC-1:0] r);
      logic [NUM_SRC-1:0] o;
      o = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         if (r[i])
         begin
            o = '0;
            o[i] = 1'b1;
         end
      end
      return o;
   endfunction : pick

   // Index of a one-hot source
   function automatic logic [ADDR_W-1:0] idx(input logic [NUM_SRC-1:0] h);
      logic [ADDR_W-1:0] o;
      o = '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (h[i])
            o = ADDR_W'(i);
      end
      return o;
   endfunction : idx

   // Unit length in bytes
   function automatic logic [ADDR_W-1:0] unit(input logic w);
      return w ? 32'h0000_0002 : 32'h0000_0001;
   endfunction : unit

   // Address update after one unit
   function automatic logic [ADDR_W-1:0] upd(input logic [ADDR_W-1:0] a,
      input addr_op_t op, input logic w);
      case (op)
         OP_INC:  return a + unit(w);
         OP_DEC:  return a - unit(w);
         default: return a;
      endcase
   endfunction : upd

   // Address wound back over n units (n of zero means 256)
   function automatic logic [ADDR_W-1:0] back(input logic [ADDR_W-1:0] a,
      input addr_op_t op, input logic w, input logic [7:0] n);
      logic [ADDR_W-1:0] span;
      span = (n == 8'h00) ? 32'h0000_0100 : {24'h00_0000, n};
      span = w ? {span[ADDR_W-2:0], 1'b0} : span;
      case (op)
         OP_INC:  return a - span;
         OP_DEC:  return a + span;
         default: return a;
      endcase
   endfunction : back

   // Set word as held now, for write back
   function automatic logic [DATA_W-1:0] setw(input logic [1:0] i,
      input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] d,
      input logic [15:0] c, input logic [7:0] b, input logic [7:0] br);
      case (i)
         W_SRC:   return s;
         W_DST:   return d;
         default: return {br, b, c};
      endcase
   endfunction : setw

   assign acc = cmd_ff.req && mem_ack_in;

   // Next-state logic of the whole engine
   always_comb
   begin
      nxt_st   = st_ff;
      nxt_base = base_ff;
      nxt_wi   = wi_ff;
      nxt_cfg  = cfg_ff;
      nxt_src  = src_ff;
      nxt_dst  = dst_ff;
      nxt_cnt  = cnt_ff;
      nxt_blk  = blk_ff;
      nxt_blkr = blkr_ff;
      nxt_dat  = dat_ff;
      nxt_cmd  = cmd_ff;
      nxt_ack  = '0;
      nxt_irq  = 1'b0;
      nxt_busy = busy_ff;
      if (acc)
         nxt_cmd.req = 1'b0;
      case (st_ff)
         // Wait for one activation, read its vector
         ST_IDLE:
         begin
            nxt_busy = 1'b0;
            if (|act_req_in)
            begin
               nxt_ack  = pick(act_req_in);
               nxt_busy = 1'b1;
               nxt_st   = ST_VEC;
               nxt_cmd  = '{1'b1, 1'b0, 1'b1,
                  vec_base_in + (idx(pick(act_req_in)) << 2), '0};
            end
         end
         // Vector gives the aligned set base
         ST_VEC:
         begin
            if (acc)
            begin
               nxt_base = mem_rdata_in & ALIGN_MASK;
               nxt_wi   = W_CFG;
               nxt_st   = ST_FETCH;
               nxt_cmd  = '{1'b1, 1'b0, 1'b1,
                  mem_rdata_in & ALIGN_MASK, '0};
            end
         end
         // Load the four set words in order
         ST_FETCH:
         begin
            if (acc)
            begin
               case (wi_ff)
                  W_CFG: nxt_cfg = xfer_cfg_t'(mem_rdata_in);
                  W_SRC: nxt_src = mem_rdata_in;
                  W_DST: nxt_dst = mem_rdata_in;
                  default:
                  begin
                     nxt_cnt  = mem_rdata_in[CNT_LSB +: 16];
                     nxt_blk  = mem_rdata_in[BLK_LSB +: 8];
                     nxt_blkr = mem_rdata_in[BLKR_LSB +: 8];
                  end
               endcase
               nxt_cmd = '{1'b1, 1'b0, cfg_ff.word_size,
                  src_ff, '0};
               if (wi_ff == W_CNT)
               begin
                  nxt_st = ST_READ;
                  nxt_cmd.addr = src_ff;
               end
               else
               begin
                  nxt_wi = wi_ff + 2'h1;
                  nxt_cmd.word = 1'b1;
                  nxt_cmd.addr = base_ff + {28'h000_0000, wi_ff + 2'h1, 2'h0};
                  if (wi_ff == W_SRC)
                     nxt_cmd.addr = base_ff + 32'h0000_0008;
               end
            end
         end
         // Read one unit from the source
         ST_READ:
         begin
            if (acc)
            begin
               nxt_dat = cfg_ff.word_size ? mem_rdata_in[15:0]
                                          : {8'h00, mem_rdata_in[7:0]};
               nxt_st  = ST_WRITE;
               nxt_cmd = '{1'b1, 1'b1, cfg_ff.word_size,
                  dst_ff, {16'h0000, nxt_dat}};
            end
         end
         // Write it, step addresses and counts
         ST_WRITE:
         begin
            if (acc)
            begin
               nxt_src = upd(src_ff, cfg_ff.src_op, cfg_ff.word_size);
               nxt_dst = upd(dst_ff, cfg_ff.dst_op, cfg_ff.word_size);
               nxt_st  = ST_WBACK;
               nxt_wi  = W_SRC;
               case (cfg_ff.mode)
                  MODE_REPEAT:
                  begin
                     nxt_cnt[7:0] = cnt_ff[7:0] - 8'h01;
                     if (cnt_ff[7:0] == 8'h01)
                     begin
                        nxt_cnt[7:0] = cnt_ff[15:8];
                        if (cfg_ff.area_dst)
                           nxt_dst = back(nxt_dst, cfg_ff.dst_op,
                              cfg_ff.word_size, cnt_ff[15:8]);
                        else
                           nxt_src = back(nxt_src, cfg_ff.src_op,
                              cfg_ff.word_size, cnt_ff[15:8]);
                     end
                  end
                  MODE_BLOCK:
                  begin
                     nxt_blk = blk_ff - 8'h01;
                     if (blk_ff != 8'h01)
                        nxt_st = ST_READ;
                     else
                     begin
                        nxt_blk = blkr_ff;
                        nxt_cnt = cnt_ff - 16'h0001;
                        if (cfg_ff.area_dst)
                           nxt_dst = back(nxt_dst, cfg_ff.dst_op,
                              cfg_ff.word_size, blkr_ff);
                        else
                           nxt_src = back(nxt_src, cfg_ff.src_op,
                              cfg_ff.word_size, blkr_ff);
                     end
                  end
                  default:
                     nxt_cnt = cnt_ff - 16'h0001;
               endcase
               if (nxt_st == ST_READ)
                  nxt_cmd = '{1'b1, 1'b0, cfg_ff.word_size, nxt_src, '0};
               else
                  nxt_cmd = '{1'b1, 1'b1, 1'b1, base_ff + 32'h0000_0004,
                     setw(W_SRC, nxt_src, nxt_dst, nxt_cnt, nxt_blk,
                     nxt_blkr)};
            end
         end
         // Store source, destination and counts back
         ST_WBACK:
         begin
            if (acc)
            begin
               if (wi_ff == W_CNT)
               begin
                  nxt_st = ST_DONE;
                  if (cfg_ff.irq_each ||
                     (cfg_ff.mode != MODE_REPEAT && cnt_ff == 16'h0000))
                     nxt_irq = 1'b1;
                  if (cfg_ff.chain_en &&
                     (!cfg_ff.chain_zero || cnt_ff == 16'h0000))
                  begin
                     nxt_base = base_ff + SET_BYTES;
                     nxt_wi   = W_CFG;
                     nxt_st   = ST_FETCH;
                     nxt_cmd  = '{1'b1, 1'b0, 1'b1,
                        base_ff + SET_BYTES, '0};
                  end
               end
               else
               begin
                  nxt_wi  = wi_ff + 2'h1;
                  nxt_cmd = '{1'b1, 1'b1, 1'b1,
                     base_ff + {28'h000_0000, wi_ff + 2'h1, 2'h0},
                     setw(wi_ff + 2'h1, src_ff, dst_ff, cnt_ff, blk_ff,
                     blkr_ff)};
               end
            end
         end
         // Sequence over
         ST_DONE:
            nxt_st = ST_IDLE;
         default:
            nxt_st = ST_IDLE;
      endcase
   end

   // Register all engine state
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         st_ff   <= ST_IDLE;
         base_ff <= '0;
         wi_ff   <= W_CFG;
         cfg_ff  <= '0;
         src_ff  <= '0;
         dst_ff  <= '0;
         cnt_ff  <= CNT_RST;
         blk_ff  <= BLK_RST;
         blkr_ff <= BLK_RST;
         dat_ff  <= '0;
         cmd_ff  <= '0;
         ack_ff  <= '0;
         irq_ff  <= 1'b0;
         busy_ff <= 1'b0;
      end
      else
      begin
         st_ff   <= nxt_st;
         base_ff <= nxt_base;
         wi_ff   <= nxt_wi;
         cfg_ff  <= nxt_cfg;
         src_ff  <= nxt_src;
         dst_ff  <= nxt_dst;
         cnt_ff  <= nxt_cnt;
         blk_ff  <= nxt_blk;
         blkr_ff <= nxt_blkr;
         dat_ff  <= nxt_dat;
         cmd_ff  <= nxt_cmd;
         ack_ff  <= nxt_ack;
         irq_ff  <= nxt_irq;
         busy_ff <= nxt_busy;
      end
   end

   // Outputs straight from flip-flops
   assign mem_cmd_out = cmd_ff;
   assign act_ack_out = ack_ff;
   assign busy_out    = busy_ff;
   assign cpu_irq_out = irq_ff;

   // Unit write accepted
   sequence s_wr;
      st_ff == ST_WRITE && acc;
   endsequence

   property p_src_upd;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_wr ##0 (cfg_ff.mode == MODE_NORMAL && cfg_ff.src_op == OP_INC)
      |=> src_ff == $past(src_ff) + unit(cfg_ff.word_size);
   endproperty
   a_src_upd: assert property (p_src_upd)
      else $error("source address not incremented");

   property p_dst_fix;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_wr ##0 (cfg_ff.mode == MODE_NORMAL && cfg_ff.dst_op == OP_FIXED)
      |=> $stable(dst_ff);
   endproperty
   a_dst_fix: assert property (p_dst_fix)
      else $error("fixed destination moved");

   property p_normal_one;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_wr ##0 cfg_ff.mode == MODE_NORMAL
      |=> st_ff == ST_WBACK && cnt_ff == $past(cnt_ff) - 16'h0001;
   endproperty
   a_normal_one: assert property (p_normal_one)
      else $error("normal mode moved more than one unit");

   property p_rep_reload;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_wr ##0 (cfg_ff.mode == MODE_REPEAT && cnt_ff[7:0] == 8'h01)
      |=> cnt_ff[7:0] == cnt_ff[15:8];
   endproperty
   a_rep_reload: assert property (p_rep_reload)
      else $error("repeat count not reloaded");

   property p_blk_cont;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_wr ##0 (cfg_ff.mode == MODE_BLOCK && blk_ff != 8'h01)
      |=> st_ff == ST_READ && cmd_ff.req;
   endproperty
   a_blk_cont: assert property (p_blk_cont)
      else $error("block ended early");

   property p_size;
      @(posedge clk_sys_in) disable iff (rst_in)
      (st_ff == ST_READ || st_ff == ST_WRITE) && cmd_ff.req
      |-> cmd_ff.word == cfg_ff.word_size;
   endproperty
   a_size: assert property (p_size)
      else $error("unit size differs from setting");

   property p_act;
      @(posedge clk_sys_in) disable iff (rst_in)
      |act_ack_out |-> busy_out && $onehot(act_ack_out) ##1 st_ff != ST_IDLE;
   endproperty
   a_act: assert property (p_act)
      else $error("activation not taken up");

   property p_irq;
      @(posedge clk_sys_in) disable iff (rst_in)
      cpu_irq_out |-> $past(st_ff) == ST_WBACK &&
      (cfg_ff.irq_each ||
      (cfg_ff.mode != MODE_REPEAT && cnt_ff == 16'h0000));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt without cause");
endmodule : data_transfer_engine

//--- verification/sys_mem_model.sv
// System bus and memory model behind the engine's memory port
`timescale 1ns/10ps
module sys_mem_model
   import xfer_engine_pkg::*;
(
   // Clock and reset
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_in,
   // Memory port
   input  xfer_engine_pkg::mem_cmd_t          mem_cmd_in,
   output logic [xfer_engine_pkg::DATA_W-1:0] mem_rdata_out,
   output logic                               mem_ack_out,
   // Stall control
   input  wire logic [1:0]                    max_wait_in
);
   logic [7:0] mem [int];  // Byte store, little endian
   int         wait_cnt;   // Stall cycles left
   int         a;          // Request address
   int         nb;         // Bytes written
   // Answer a held request after a random stall
   always @(posedge clk_sys_in)
   begin
      a = int'(mem_cmd_in.addr);
      // Read data is garbage outside the ack cycle
      mem_rdata_out <= ~mem_rdata_out;
      if (rst_in)
      begin
         mem_ack_out   <= 1'b0;
         mem_rdata_out <= 32'h0;
         wait_cnt = 0;
      end
      else if (mem_ack_out)
         mem_ack_out <= 1'b0;  // One-cycle pulse
      else if (mem_cmd_in.req && wait_cnt > 0)
         wait_cnt--;           // Slow answer
      else if (mem_cmd_in.req)
      begin
         mem_ack_out   <= 1'b1;
         wait_cnt = $urandom_range(max_wait_in);
         mem_rdata_out <= {mem[a+3], mem[a+2], mem[a+1], mem[a]};
         // Set area below 4 KiB holds whole 32-bit words
         nb = a < 'h1000 ? 4 : mem_cmd_in.word ? 2 : 1;
         if (mem_cmd_in.we)
            for (int k = 0; k < nb; k++)
               mem[a+k] = mem_cmd_in.wdata[8*k +: 8];
      end
   end
endmodule : sys_mem_model

//--- verification/testbench.sv
// Self-checking bench: random parameter sets against a reference model
`timescale 1ns/10ps
module testbench;
   import xfer_engine_pkg::*;
   localparam int VEC  = 'h100;           // Vector table base
   localparam int SETS = 'h400;           // First parameter set
   logic              clk_sys_in = 1'b0;  // System clock
   logic              rst_in     = 1'b1;  // Synchronous reset
   logic [7:0]        act_req    = 8'h00; // Activation requests
   logic [7:0]        act_ack;            // Accepted source
   mem_cmd_t          cmd;                // Memory command
   logic [DATA_W-1:0] rdata;              // Memory read data
   logic              mack;               // Memory acknowledge
   logic              busy;               // Engine busy
   logic              irq;                // Processor interrupt
   logic [1:0]        max_wait   = 2'h0;  // Memory stall bound
   int                fails      = 0;     // Mismatches
   int                n_compared = 0;     // Comparisons
   logic [7:0]        xm [int];           // Expected memory bytes
   // 250 MHz clock
   always #2 clk_sys_in = ~clk_sys_in;
   // Engine under test
   data_transfer_engine #(.NUM_SRC(8)) i_data_transfer_engine
   (
      .clk_sys_in   (clk_sys_in),
      .rst_in       (rst_in),
      .act_req_in   (act_req),
      .vec_base_in  (32'h0000_0100),
      .act_ack_out  (act_ack),
      .mem_cmd_out  (cmd),
      .mem_rdata_in (rdata),
      .mem_ack_in   (mack),
      .busy_out     (busy),
      .cpu_irq_out  (irq)
   );
   // Memory behind the engine
   sys_mem_model i_sys_mem_model
   (
      .clk_sys_in    (clk_sys_in),
      .rst_in        (rst_in),
      .mem_cmd_in    (cmd),
      .mem_rdata_out (rdata),
      .mem_ack_out   (mack),
      .max_wait_in   (max_wait)
   );
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want)
      begin
         fails++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   // Print counts and verdict
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // Word of model memory
   function automatic logic [31:0] rd32(input int a);
      return {i_sys_mem_model.mem[a+3], i_sys_mem_model.mem[a+2],
              i_sys_mem_model.mem[a+1], i_sys_mem_model.mem[a]};
   endfunction : rd32
   // Word into memory, or into expected bytes
   task automatic put32(input int a, input logic [31:0] v, input bit x);
      for (int k = 0; k < 4; k++)
         if (x)
            xm[a+k] = v[8*k +: 8];
         else
            i_sys_mem_model.mem[a+k] = v[8*k +: 8];
   endtask : put32
   // Random set; t picks source op, destination op and mode
   task automatic make_set(input int b, input int t, input bit last);
      logic [31:0] c;
      logic [7:0]  rl;
      logic [15:0] n;
      c      = $urandom;
      c[1:0] = 2'(t % 3);
      c[3:2] = 2'((t / 3) % 3);
      c[5:4] = 2'((t / 9) % 3);
      c[8]   = c[8] & ~last;
      rl     = 8'($urandom_range(3, 1));
      n = c[5:4] == 2'h1 ? {rl, 8'($urandom_range(3, 1))}
                         : 16'($urandom_range(2));
      put32(b, c, 0);
      put32(b + 4, 'h2800 + 2 * $urandom_range(64), 0);
      put32(b + 8, 'h6800 + 2 * $urandom_range(64), 0);
      put32(b + 12, {rl, rl, n}, 0);  // Block counter starts at reload
   endtask : make_set
   // Reference for one set: moves, write back, irq and chain
   task automatic model_set(input int b, output bit due, output bit ch);
      logic [31:0] c;
      int          s, d, cnt, blk, br, n, sz, ss, ds;
      c   = rd32(b);
      s   = rd32(b + 4);
      d   = rd32(b + 8);
      cnt = rd32(b + 12) & 'hffff;
      blk = (rd32(b + 12) >> 16) & 'hff;
      br  = rd32(b + 12) >> 24;
      sz  = c[7] ? 2 : 1;
      ss  = c[1:0] == 2'h1 ? sz : c[1:0] == 2'h2 ? -sz : 0;
      ds  = c[3:2] == 2'h1 ? sz : c[3:2] == 2'h2 ? -sz : 0;
      n   = c[5:4] != 2'h2 ? 1 : blk == 0 ? 256 : blk;
      // Unit moves
      for (int u = 0; u < n; u++)
      begin
         for (int k = 0; k < sz; k++)
            xm[d+k] = i_sys_mem_model.mem[s+k];
         s += ss;
         d += ds;
      end
      if (c[5:4] == 2'h1)
      begin
         // Low byte counts, high byte reloads
         cnt = (cnt & 'hff00) | ((cnt - 1) & 'hff);
         n   = (cnt & 'hff) == 0 ? cnt >> 8 : 0;
         cnt = cnt | n;
      end
      else
      begin
         cnt = (cnt - 1) & 'hffff;
         n   = c[5:4] == 2'h2 ? n : 0;
         blk = c[5:4] == 2'h2 ? br : blk;
      end
      // Wind the area address back
      if (c[6])
         d -= ds * n;
      else
         s -= ss * n;
      put32(b + 4, s, 1);
      put32(b + 8, d, 1);
      put32(b + 12, {br[7:0], blk[7:0], cnt[15:0]}, 1);
      due = c[10] || (c[5:4] != 2'h1 && cnt == 0);
      ch  = c[8] && (!c[9] || cnt == 0);
   endtask : model_set
   // Main sequence
   initial
   begin
      int i, k, seen_n, n_due;
      bit due, ch;
      void'($urandom(32'hafe2fc37));
      for (k = 'h2000; k < 'h3000; k++)
         i_sys_mem_model.mem[k] = 8'($urandom);
      repeat (4) @(negedge clk_sys_in);
      rst_in = 1'b0;
      check({busy, irq, act_ack, cmd.req}, 32'h0);
      for (int t = 0; t < 45; t++)
      begin
         i        = $urandom_range(7);
         max_wait = 2'($urandom_range(3));
         xm.delete();
         put32(VEC + 4 * i, SETS + 'h40 * i, 0);
         make_set(SETS + 'h40 * i, t % 27, 0);
         make_set(SETS + 'h40 * i + 16, $urandom_range(26), 1);
         k      = SETS + 'h40 * i;
         ch     = 1'b1;
         n_due  = 0;
         while (ch)
         begin
            model_set(k, due, ch);
            n_due += due;
            k += 16;
         end
         // Lowest requesting source wins
         act_req = 8'h1 << i | 8'($urandom) & ~((8'h2 << i) - 8'h1);
         k = 0;
         while (act_ack === 8'h00)
         begin
            @(negedge clk_sys_in);
            if (++k > 20)
            begin
               fails++;
               tally_and_finish();
            end
         end
         check(act_ack, 8'h1 << i);
         check(busy, 1'b1);
         act_req = 8'h00;
         seen_n  = 0;
         while (busy === 1'b1)
         begin
            @(negedge clk_sys_in);
            seen_n += (irq === 1'b1);
            if (++k > 12000)
            begin
               fails++;
               tally_and_finish();
            end
         end
         // One pulse per set of the chain that is due one
         check(seen_n, n_due);
         foreach (xm[a])
            check(i_sys_mem_model.mem[a], xm[a]);
      end
      tally_and_finish();
   end
endmodule : testbench
